// ==== verilog/vescp_top.sv ====
// two-wire serial control port and first control registers of the encoder
// ==========================================================
module vescp_top (
   // core clock and reset
   input wire logic clk,
   input wire logic srst,
   // link sampling clock
   input wire logic link_clk,
   // reset pin, active low
   input wire logic reset_n,
   // serial bus
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic bus_address_select_pin,
   // register images
   output logic [7:0] power_control,
   output logic [7:0] input_mode_select,
   output logic [7:0] output_mode_control_0,
   // decoded controls
   output logic sleep_mode,
   output logic pll_power_down,
   output logic [5:0] dac_power_on,
   output logic [2:0] input_mode,
   output logic rise_edge_y_sel,
   output logic clock_align,
   output logic timing_gen_reset
);

   // ==========================================================
   // state of the link domain
   typedef struct packed {
      logic [1:0] sel_sync;
      logic [1:0] rst_sync;
      vescp_pkg::vescp_state_t st;
      vescp_pkg::vescp_kind_t kind;
      logic rw;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] ptr;
      logic [7:0] r_pwr;
      logic [7:0] r_mode;
      logic [7:0] r_out0;
      logic prev_scl;
      logic prev_sda;
      logic oe;
      logic req_tgl;
   } vescp_link_t;

   // ==========================================================
   // state of the core domain
   typedef struct packed {
      logic [1:0] nrst_sync;
      logic [7:0] pwr;
      logic [7:0] mode;
      logic [7:0] out0;
      logic sleep;
      logic pll_dn;
      logic [5:0] dac_on;
      logic [2:0] in_mode;
      logic edge_sel;
      logic align;
      logic tg_rst;
   } vescp_core_t;

   vescp_link_t lk_q;
   vescp_link_t lk_d;
   vescp_core_t co_q;
   vescp_core_t co_d;

   logic lrst;
   logic scl_f;
   logic sda_f;
   logic start_cond;
   logic stop_cond;
   logic scl_rise;
   logic scl_fall;
   logic [6:0] my_addr;
   logic [23:0] img_word;
   logic img_new;
   logic crst;

   vescp_xfer_if xfer ();

   // ==========================================================
   // line conditioning
   assign lrst = lk_q.rst_sync[1];

   vescp_glitch_filter u_scl_filt (
      .clk (link_clk),
      .rst (lrst),
      .bypass (lk_q.sel_sync[1]),
      .din (scl),
      .dout (scl_f)
   );

   vescp_glitch_filter u_sda_filt (
      .clk (link_clk),
      .rst (lrst),
      .bypass (lk_q.sel_sync[1]),
      .din (sda_i),
      .dout (sda_f)
   );

   // ==========================================================
   // bus conditions
   // only one condition per high phase is expected, so start wins a tie
   assign start_cond = scl_f && lk_q.prev_scl && lk_q.prev_sda && !sda_f;
   assign stop_cond = scl_f && lk_q.prev_scl && !lk_q.prev_sda && sda_f;
   assign scl_rise = scl_f && !lk_q.prev_scl;
   assign scl_fall = !scl_f && lk_q.prev_scl;

   // pin supplies bit A1 of the own address
   always_comb begin
      my_addr = vescp_pkg::DEV_ADDR_BASE;
      my_addr[vescp_pkg::ADDR_SEL_BIT] = lk_q.sel_sync[1];
   end

   // readable registers only; the pointer has no read path
   // anything past the top returns the highest register
   function automatic logic [7:0] read_reg(input logic [7:0] p, input vescp_link_t s);
      logic [7:0] v;
      v = s.r_out0;
      if (p == vescp_pkg::REG_POWER) begin
         v = s.r_pwr;
      end else if (p == vescp_pkg::REG_MODE) begin
         v = s.r_mode;
      end
      return v;
   endfunction

   // ==========================================================
   // link engine
   always_comb begin
      lk_d = lk_q;
      lk_d.sel_sync = {lk_q.sel_sync[0], bus_address_select_pin};
      // either reset source restores defaults
      lk_d.rst_sync = {lk_q.rst_sync[0], srst | ~reset_n};
      lk_d.prev_scl = scl_f;
      lk_d.prev_sda = sda_f;
      if (lrst) begin
         lk_d.st = vescp_pkg::ST_IDLE;
         lk_d.kind = vescp_pkg::KIND_ADDR;
         lk_d.rw = 1'b0;
         lk_d.bitcnt = 4'h0;
         lk_d.shreg = 8'h00;
         lk_d.ptr = 8'h00;
         lk_d.r_pwr = vescp_pkg::RST_POWER;
         lk_d.r_mode = vescp_pkg::RST_MODE;
         lk_d.r_out0 = vescp_pkg::RST_OUT0;
         lk_d.oe = 1'b0;
         lk_d.req_tgl = 1'b0;
      end else if (start_cond) begin
         // start or repeated start restarts address reception
         lk_d.st = vescp_pkg::ST_RX;
         lk_d.kind = vescp_pkg::KIND_ADDR;
         lk_d.bitcnt = 4'h0;
         lk_d.oe = 1'b0;
      end else if (stop_cond) begin
         // stop ends any transfer, expected or not
         lk_d.st = vescp_pkg::ST_IDLE;
         lk_d.oe = 1'b0;
      end else begin
         unique case (lk_q.st)
            vescp_pkg::ST_IDLE: begin
               lk_d.oe = 1'b0;
            end
            vescp_pkg::ST_RX: begin
               if (scl_rise) begin
                  // msb first
                  lk_d.shreg = {lk_q.shreg[6:0], sda_f};
                  lk_d.bitcnt = 4'(lk_q.bitcnt + 4'h1);
               end else if (scl_fall && lk_q.bitcnt == vescp_pkg::BITS_PER_BYTE) begin
                  lk_d.st = vescp_pkg::ST_IDLE;
                  lk_d.bitcnt = 4'h0;
                  unique case (lk_q.kind)
                     vescp_pkg::KIND_ADDR: begin
                        if (lk_q.shreg[7:1] == my_addr) begin
                           // ack own address only
                           lk_d.st = vescp_pkg::ST_ACK;
                           lk_d.oe = 1'b1;
                           lk_d.rw = lk_q.shreg[0];
                        end
                     end
                     vescp_pkg::KIND_PTR: begin
                        if (lk_q.shreg <= vescp_pkg::REG_LAST) begin
                           // second byte loads the pointer
                           lk_d.ptr = lk_q.shreg;
                           lk_d.kind = vescp_pkg::KIND_DATA;
                           lk_d.st = vescp_pkg::ST_ACK;
                           lk_d.oe = 1'b1;
                        end
                        // otherwise no ack and idle
                        // subcarrier registers sit above the top, so refused too
                     end
                     vescp_pkg::KIND_DATA: begin
                        if (lk_q.ptr <= vescp_pkg::REG_LAST) begin
                           if (lk_q.ptr == vescp_pkg::REG_POWER) begin
                              lk_d.r_pwr = lk_q.shreg;
                           end else if (lk_q.ptr == vescp_pkg::REG_MODE) begin
                              lk_d.r_mode = lk_q.shreg;
                           end else begin
                              lk_d.r_out0 = lk_q.shreg;
                           end
                           lk_d.req_tgl = ~lk_q.req_tgl;
                           lk_d.ptr = 8'(lk_q.ptr + 8'h01);
                           lk_d.st = vescp_pkg::ST_ACK;
                           lk_d.oe = 1'b1;
                        end
                        // past the top: byte dropped, no ack, idle
                     end
                     default: begin
                        lk_d.st = vescp_pkg::ST_IDLE;
                     end
                  endcase
               end
            end
            vescp_pkg::ST_ACK: begin
               if (scl_fall) begin
                  // ninth clock over, release the line
                  lk_d.oe = 1'b0;
                  lk_d.bitcnt = 4'h0;
                  if (lk_q.kind == vescp_pkg::KIND_ADDR && lk_q.rw) begin
                     // read starts at the pointer left by an earlier write
                     lk_d.st = vescp_pkg::ST_TX;
                     lk_d.shreg = read_reg(lk_q.ptr, lk_q);
                     lk_d.oe = ~lk_d.shreg[7];
                  end else begin
                     lk_d.st = vescp_pkg::ST_RX;
                     if (lk_q.kind == vescp_pkg::KIND_ADDR) begin
                        lk_d.kind = vescp_pkg::KIND_PTR;
                     end
                  end
               end
            end
            vescp_pkg::ST_TX: begin
               if (scl_rise) begin
                  lk_d.bitcnt = 4'(lk_q.bitcnt + 4'h1);
               end else if (scl_fall) begin
                  if (lk_q.bitcnt == vescp_pkg::BITS_PER_BYTE) begin
                     lk_d.oe = 1'b0;
                     lk_d.st = vescp_pkg::ST_RACK;
                  end else begin
                     // open drain: enable only for zero bits
                     lk_d.shreg = {lk_q.shreg[6:0], 1'b0};
                     lk_d.oe = ~lk_q.shreg[6];
                  end
               end
            end
            vescp_pkg::ST_RACK: begin
               if (scl_rise) begin
                  if (sda_f) begin
                     // master nak ends the read
                     lk_d.st = vescp_pkg::ST_IDLE;
                  end else begin
                     lk_d.bitcnt = vescp_pkg::BIT_ACKED;
                     // saturates one past the top; reads clamp
                     if (lk_q.ptr <= vescp_pkg::REG_LAST) begin
                        lk_d.ptr = 8'(lk_q.ptr + 8'h01);
                     end
                  end
               end else if (scl_fall && lk_q.bitcnt == vescp_pkg::BIT_ACKED) begin
                  lk_d.st = vescp_pkg::ST_TX;
                  lk_d.bitcnt = 4'h0;
                  lk_d.shreg = read_reg(lk_q.ptr, lk_q);
                  lk_d.oe = ~lk_d.shreg[7];
               end
            end
            default: begin
               lk_d.st = vescp_pkg::ST_IDLE;
               lk_d.oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk) begin
      lk_q <= lk_d;
   end

   assign sda_o = 1'b0;
   assign sda_oe = lk_q.oe;

   // ==========================================================
   // crossing to the core domain
   assign xfer.word = {lk_q.r_out0, lk_q.r_mode, lk_q.r_pwr};
   assign xfer.req_tgl = lk_q.req_tgl;

   vescp_word_sync u_word_sync (
      .clk (clk),
      .srst (crst),
      .xfer (xfer),
      .word_o (img_word),
      .new_o (img_new)
   );

   // ==========================================================
   // core domain registers and decode
   assign crst = srst | co_q.nrst_sync[1];

   always_comb begin
      co_d = co_q;
      co_d.nrst_sync = {co_q.nrst_sync[0], ~reset_n};
      if (crst) begin
         co_d.pwr = vescp_pkg::RST_POWER;
         co_d.mode = vescp_pkg::RST_MODE;
         co_d.out0 = vescp_pkg::RST_OUT0;
      end else if (img_new) begin
         co_d.pwr = img_word[7:0];
         co_d.mode = img_word[15:8];
         co_d.out0 = img_word[23:16];
      end
      // sleep forces all DACs and the PLL off
      co_d.sleep = co_d.pwr[vescp_pkg::PWR_SLEEP_BIT];
      co_d.pll_dn = co_d.pwr[vescp_pkg::PWR_PLL_BIT] | co_d.sleep;
      co_d.dac_on = co_d.sleep ? 6'h00 : co_d.pwr[vescp_pkg::PWR_DAC_MSB:vescp_pkg::PWR_DAC_LSB];
      co_d.in_mode = co_d.mode[vescp_pkg::MODE_IN_MSB:vescp_pkg::MODE_IN_LSB];
      co_d.edge_sel = co_d.mode[vescp_pkg::MODE_EDGE_BIT];
      co_d.align = co_d.mode[vescp_pkg::MODE_ALIGN_BIT];
      co_d.tg_rst = crst;
   end

   always_ff @(posedge clk) begin
      co_q <= co_d;
   end

   assign power_control = co_q.pwr;
   assign input_mode_select = co_q.mode;
   assign output_mode_control_0 = co_q.out0;
   assign sleep_mode = co_q.sleep;
   assign pll_power_down = co_q.pll_dn;
   assign dac_power_on = co_q.dac_on;
   assign input_mode = co_q.in_mode;
   assign rise_edge_y_sel = co_q.edge_sel;
   assign clock_align = co_q.align;
   assign timing_gen_reset = co_q.tg_rst;

endmodule

// ==== verilog/vescp_pkg.sv ====
// constants and types shared by the serial control port design
package vescp_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] REG_POWER = 8'h00;
   localparam logic [7:0] REG_MODE = 8'h01;
   localparam logic [7:0] REG_OUT0 = 8'h02;
   localparam logic [7:0] REG_LAST = REG_OUT0;

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_POWER = 8'hFC;
   localparam logic [7:0] RST_MODE = 8'h38;
   localparam logic [7:0] RST_OUT0 = 8'h20;

   // ==========================================================
   // field positions
   localparam int PWR_SLEEP_BIT = 0;
   localparam int PWR_PLL_BIT = 1;
   localparam int PWR_DAC_LSB = 2;
   localparam int PWR_DAC_MSB = 7;
   localparam int MODE_EDGE_BIT = 1;
   localparam int MODE_ALIGN_BIT = 3;
   localparam int MODE_IN_LSB = 4;
   localparam int MODE_IN_MSB = 6;
   localparam int ADDR_SEL_BIT = 1;

   // ==========================================================
   // bus address, arbitrary value; bit 1 comes from the select pin
   localparam logic [6:0] DEV_ADDR_BASE = 7'h11;

   // ==========================================================
   // timing
   localparam int FILT_NS = 50;
   localparam int LINK_PERIOD_NS = 48;
   localparam int FILT_CYC_INT = (FILT_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam logic [1:0] FILT_CYC = 2'(FILT_CYC_INT);
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_ACKED = 4'h9;

   // ==========================================================
   // link engine states and byte kinds
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX = 3'h1,
      ST_ACK = 3'h3,
      ST_TX = 3'h2,
      ST_RACK = 3'h6
   } vescp_state_t;

   typedef enum logic [1:0] {
      KIND_ADDR = 2'h0,
      KIND_PTR = 2'h1,
      KIND_DATA = 2'h2
   } vescp_kind_t;

endpackage

// ==== verilog/vescp_xfer_if.sv ====
// register image carried from the link domain to the core domain
interface vescp_xfer_if;
   logic [23:0] word;
   logic req_tgl;

   modport src (
      output word,
      output req_tgl
   );

   modport dst (
      input word,
      input req_tgl
   );
endinterface

// ==== verilog/vescp_glitch_filter.sv ====
// two-flop synchroniser and optional short-pulse filter for one bus line
module vescp_glitch_filter (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic bypass,
   // line
   input wire logic din,
   output logic dout
);

   typedef struct packed {
      logic [1:0] sync;
      logic [1:0] cnt;
      logic out;
   } vescp_filt_t;

   vescp_filt_t f_q;
   vescp_filt_t f_d;

   // ==========================================================
   // filter
   always_comb begin
      f_d = f_q;
      f_d.sync = {f_q.sync[0], din};
      if (rst) begin
         f_d.cnt = 2'h0;
         f_d.out = 1'b1;
      end else if (bypass || f_q.sync[1] == f_q.out) begin
         // bypass trades noise rejection for bandwidth
         f_d.out = f_q.sync[1];
         f_d.cnt = 2'h0;
      end else if (2'(f_q.cnt + 2'h1) >= vescp_pkg::FILT_CYC) begin
         // level held long enough to be real
         f_d.out = f_q.sync[1];
         f_d.cnt = 2'h0;
      end else begin
         f_d.cnt = 2'(f_q.cnt + 2'h1);
      end
   end

   always_ff @(posedge clk) begin
      f_q <= f_d;
   end

   assign dout = f_q.out;

endmodule

// ==== verilog/vescp_word_sync.sv ====
// toggle-handshake receiver for the register image in the core domain
module vescp_word_sync (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // image from the link domain
   vescp_xfer_if.dst xfer,
   // captured image
   output logic [23:0] word_o,
   output logic new_o
);

   typedef struct packed {
      logic [2:0] tgl;
      logic [23:0] word;
      logic pulse;
   } vescp_ws_t;

   vescp_ws_t w_q;
   vescp_ws_t w_d;

   // ==========================================================
   // crossing
   // word is held steady by the source long before the toggle lands here
   always_comb begin
      w_d = w_q;
      w_d.tgl = {w_q.tgl[1:0], xfer.req_tgl};
      w_d.pulse = 1'b0;
      if (srst) begin
         w_d.tgl = 3'h0;
         w_d.word = 24'h000000;
      end else if (w_q.tgl[2] != w_q.tgl[1]) begin
         w_d.word = xfer.word;
         w_d.pulse = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      w_q <= w_d;
   end

   assign word_o = w_q.word;
   assign new_o = w_q.pulse;

endmodule

// ==== dv/vescp_top_sva.sv ====
// concurrent checks on the serial control port top ports
module vescp_top_sva (
   // clocks and resets
   input wire logic clk,
   input wire logic srst,
   input wire logic link_clk,
   input wire logic reset_n,
   // bus
   input wire logic scl,
   input wire logic sda_o,
   input wire logic sda_oe,
   // register images
   input wire logic [7:0] power_control,
   input wire logic [7:0] input_mode_select,
   input wire logic [7:0] output_mode_control_0,
   // decoded controls
   input wire logic sleep_mode,
   input wire logic pll_power_down,
   input wire logic [5:0] dac_power_on,
   input wire logic [2:0] input_mode,
   input wire logic rise_edge_y_sel,
   input wire logic clock_align,
   input wire logic timing_gen_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====
   // reset
   srst_values_a: assert property (@(posedge clk) disable iff (!reset_n) srst |=>
      power_control == vescp_pkg::RST_POWER && input_mode_select == vescp_pkg::RST_MODE
      && output_mode_control_0 == vescp_pkg::RST_OUT0) else $error("images not at defaults");
   pin_reset_a: assert property (@(posedge clk) disable iff (srst)
      !reset_n [*6] |-> power_control == vescp_pkg::RST_POWER) else $error("reset pin ignored");
   tgr_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      srst |=> timing_gen_reset) else $error("timing reset missing");
   oe_reset_a: assert property (@(posedge link_clk) disable iff (!reset_n)
      srst [*5] |-> !sda_oe) else $error("sda driven in reset");
   // =====
   // bus pin
   sda_low_a: assert property (@(posedge clk) disable iff (srst)
      sda_o == 1'b0) else $error("sda output not low");
   // a change while scl is high would look like a start or stop
   oe_edge_a: assert property (@(posedge link_clk) disable iff (srst)
      $changed(sda_oe) |-> !scl) else $error("sda moved with scl high");
   oe_bound_a: assert property (@(posedge link_clk) disable iff (srst)
      $rose(sda_oe) |-> ##[1:400] !sda_oe) else $error("sda held low too long");
   // =====
   // decode
   // decoded controls load on the same edge as the images
   sleep_dec_a: assert property (@(posedge clk) disable iff (srst)
      sleep_mode == power_control[0]
      && pll_power_down == (power_control[1] | power_control[0])) else $error("sleep decode");
   dac_dec_a: assert property (@(posedge clk) disable iff (srst)
      dac_power_on == (power_control[0] ? 6'h00 : power_control[7:2]))
      else $error("dac decode");
   mode_dec_a: assert property (@(posedge clk) disable iff (srst)
      {input_mode, rise_edge_y_sel, clock_align} == {input_mode_select[6:4],
      input_mode_select[1], input_mode_select[3]}) else $error("mode decode");
   cover property (@(posedge clk) $rose(sleep_mode));
   cover property (@(posedge link_clk) $rose(sda_oe));
   cover property (@(posedge clk) $fell(reset_n));
endmodule

bind vescp_top vescp_top_sva chk (
   .clk(clk), .srst(srst), .link_clk(link_clk), .reset_n(reset_n), .scl(scl), .sda_o(sda_o),
   .sda_oe(sda_oe), .power_control(power_control), .input_mode_select(input_mode_select),
   .output_mode_control_0(output_mode_control_0), .sleep_mode(sleep_mode),
   .pll_power_down(pll_power_down), .dac_power_on(dac_power_on), .input_mode(input_mode),
   .rise_edge_y_sel(rise_edge_y_sel), .clock_align(clock_align), .timing_gen_reset(timing_gen_reset)
);

// ==== dv/vescp_host.sv ====
// bus master model driving the two-wire lines of the control port
module vescp_host (
   // clock
   input wire logic clk,
   // bus
   output logic scl,
   output logic sda_lo,
   input wire logic sda,
   // observed byte and ninth bit
   output logic res_v,
   output logic [8:0] res
);
   timeunit 1ns;
   timeprecision 1ps;
   logic gl = 1'b0;
   initial begin
      scl = 1'b1;
      sda_lo = 1'b0;
      res_v = 1'b0;
      res = 9'h000;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // =====
   // framing, one condition per high phase
   task automatic start();
      sda_lo <= 1'b0;
      wt(4);
      scl <= 1'b1;
      wt(4);
      sda_lo <= 1'b1;
      wt(4);
      scl <= 1'b0;
      wt(4);
   endtask
   task automatic stop();
      sda_lo <= 1'b1;
      wt(4);
      scl <= 1'b1;
      wt(4);
      sda_lo <= 1'b0;
      wt(4);
   endtask
   // =====
   // nb bits msb first, ninth bit only for a whole byte
   task automatic xfer(input logic [7:0] b, input logic rd, input logic mack, input int nb);
      logic [7:0] seen;
      seen = 8'h00;
      for (int i = 7; i > 7 - nb; i--) begin
         sda_lo <= rd ? 1'b0 : !b[i];
         wt(4);
         scl <= 1'b1;
         wt(2);
         seen[i] = sda;
         // off-edge pulse under 50 ns, must be filtered out
         if (gl) begin
            sda_lo <= !sda_lo;
            #40;
            sda_lo <= !sda_lo;
         end
         wt(2);
         scl <= 1'b0;
         wt(1);
      end
      if (nb == 8) begin
         sda_lo <= rd & mack;
         wt(4);
         scl <= 1'b1;
         wt(2);
         res <= {seen, sda};
         res_v <= 1'b1;
         wt(1);
         res_v <= 1'b0;
         wt(1);
         scl <= 1'b0;
         wt(1);
      end
   endtask
endmodule

// ==== dv/vescp_top_tb_top.sv ====
// self-checking bench for the serial control port
module vescp_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // =====
   // clocks, pins and bookkeeping
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic srst = 1'b1;
   logic reset_n = 1'b1;
   logic pin = 1'b0;
   logic scl, sda_lo, sda, sda_o, sda_oe, res_v, sleep, pll, edge_y, align, tgr;
   logic [8:0] res;
   logic [7:0] pc, ims, omc;
   logic [5:0] dac;
   logic [2:0] imode;
   logic [7:0] mdl [3];
   logic [8:0] exp_q [$];
   int ptr = 0;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   always #50 clk = ~clk;
   initial begin
      #13;
      forever #24 link_clk = ~link_clk;
   end
   // open drain with pull-up: released line reads high
   assign sda = !(sda_oe | sda_lo);
   vescp_top dut (
      .clk(clk), .srst(srst), .link_clk(link_clk), .reset_n(reset_n),
      .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .bus_address_select_pin(pin),
      .power_control(pc), .input_mode_select(ims), .output_mode_control_0(omc),
      .sleep_mode(sleep), .pll_power_down(pll), .dac_power_on(dac), .input_mode(imode),
      .rise_edge_y_sel(edge_y), .clock_align(align), .timing_gen_reset(tgr)
   );
   vescp_host host (.clk(clk), .scl(scl), .sda_lo(sda_lo), .sda(sda), .res_v(res_v), .res(res));
   // =====
   // reporting
   task automatic check(input logic [23:0] seen, input logic [23:0] want);
      n_tests++;
      if (seen !== want) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic finish_test();
      $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   always @(posedge clk) begin
      if (res_v === 1'b1) begin
         if (exp_q.size() == 0) check(24'h0, 24'h1);
         else check(res, exp_q.pop_front());
      end
   end
   // =====
   // bus sequences
   function automatic logic [6:0] my_addr();
      return {vescp_pkg::DEV_ADDR_BASE[6:2], pin, vescp_pkg::DEV_ADDR_BASE[0]};
   endfunction
   task automatic byte_x(input logic [7:0] v, input logic rd, input logic mack, input logic [8:0] want);
      exp_q.push_back(want);
      host.xfer(v, rd, mack, 8);
   endtask
   task automatic rd_burst(input int n);
      host.start();
      byte_x({my_addr(), 1'b1}, 1'b0, 1'b0, {my_addr(), 1'b1, 1'b0});
      for (int i = 0; i < n; i++) begin
         byte_x(8'h00, 1'b1, i < n - 1, {mdl[ptr], i == n - 1});
         if (i < n - 1 && ptr < 2) ptr++;
      end
      host.stop();
   endtask
   task automatic wr_burst(input logic [7:0] p, input int n, input logic s);
      logic [7:0] v;
      host.start();
      byte_x({my_addr(), 1'b0}, 1'b0, 1'b0, {my_addr(), 1'b0, 1'b0});
      byte_x(p, 1'b0, 1'b0, {p, p > 8'h02});
      // a refused pointer leaves the device pointer where it was
      if (p <= 8'h02) ptr = p;
      for (int i = 0; i < n && p <= 8'h02; i++) begin
         v = 8'($urandom()) | {7'h00, s};
         if (ptr == 2) v = v & 8'hFC;
         byte_x(v, 1'b0, 1'b0, {v, ptr > 2});
         if (ptr > 2) break;
         mdl[ptr] = v;
         ptr++;
      end
      host.stop();
   endtask
   task automatic chk_regs();
      repeat (10) @(posedge clk);
      check({pc, ims, omc}, {mdl[0], mdl[1], mdl[2]});
      check({sleep, pll, dac}, {mdl[0][0], mdl[0][1] | mdl[0][0], mdl[0][0] ? 6'h00 : mdl[0][7:2]});
      check({imode, edge_y, align}, {mdl[1][6:4], mdl[1][1], mdl[1][3]});
   endtask
   // =====
   // scenarios
   initial begin
      void'($urandom(26));
      mdl = '{vescp_pkg::RST_POWER, vescp_pkg::RST_MODE, vescp_pkg::RST_OUT0};
      repeat (12) @(posedge clk);
      check(tgr, 1'b1);
      srst <= 1'b0;
      chk_regs();
      check({dac, imode, align, tgr}, {6'h3F, 3'h3, 1'b1, 1'b0});
      rd_burst(4);
      for (int k = 0; k < 2; k++) begin
         pin <= k[0];
         // glitches only with the filter on
         host.gl = (k == 0);
         wr_burst(8'h00, 4, k == 0);
         host.gl = 1'b0;
         chk_regs();
         wr_burst(8'h00, 0, 1'b0);
         rd_burst(4);
         wr_burst(8'h03 + 8'($urandom_range(k * 200)), 1, 1'b0);
         host.start();
         byte_x({my_addr() ^ 7'h02, 1'b0}, 1'b0, 1'b0, {my_addr() ^ 7'h02, 1'b0, 1'b1});
         byte_x(8'h00, 1'b0, 1'b0, 9'h001);
         host.stop();
         chk_regs();
      end
      // repeated start inside a data byte abandons it
      host.start();
      byte_x({my_addr(), 1'b0}, 1'b0, 1'b0, {my_addr(), 1'b0, 1'b0});
      byte_x(8'h01, 1'b0, 1'b0, 9'h002);
      host.xfer(8'h5A, 1'b0, 1'b0, 4);
      ptr = 1;
      rd_burst(1);
      chk_regs();
      reset_n <= 1'b0;
      repeat (6) @(posedge clk);
      check(tgr, 1'b1);
      reset_n <= 1'b1;
      mdl = '{vescp_pkg::RST_POWER, vescp_pkg::RST_MODE, vescp_pkg::RST_OUT0};
      chk_regs();
      finish_test();
   end
endmodule
